// file: pct_pkg.sv
// Constants, types and register map of the bank auto-close scheduler.
// Assumes a single 100 MHz clock shared by the APB slave and command port.
package pct_pkg;

    // ------------------------------------------------------------------
    // Sizes and clock
    // ------------------------------------------------------------------
    localparam int          NUM_BANKS    = 8;
    localparam int          CNT_W        = 8;
    localparam int          CLK_PERIOD_NS = 10;

    // ------------------------------------------------------------------
    // Times in ns and derived cycle counts (least times round up)
    // ------------------------------------------------------------------
    localparam int          ROW_ACTIVE_MIN_NS   = 42;
    localparam int          ROW_CLOSE_TIME_NS   = 18;
    localparam int          ROW_ACTIVE_MIN_CYC  =
        (ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ROW_CLOSE_TIME_CYC  =
        (ROW_CLOSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  CLOSE_SPACING_CYC   = 8'h04;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  MODE_ONE_OFS  = 8'h00;
    localparam logic [7:0]  MODE_TWO_OFS  = 8'h04;
    localparam logic [7:0]  ROW_TIME_OFS  = 8'h08;
    localparam logic [7:0]  CONTROL_OFS   = 8'h0c;
    localparam logic [7:0]  STATUS_OFS    = 8'h10;

    // Field positions.
    localparam int          RD_POSTAMBLE_BIT  = 7;
    localparam int          WR_PREAMBLE_BIT   = 2;
    localparam int          WR_RECOV_LSB      = 8;
    localparam int          RD_CLOSE_LSB      = 0;
    localparam int          WR_LAT_LSB        = 8;
    localparam int          ROW_ACT_LSB       = 0;
    localparam int          ROW_CLOSE_LSB     = 8;
    localparam int          BL32_BIT          = 0;
    localparam int          TERM_EN_BIT       = 1;
    localparam int          VIOL_BANK_BIT     = 24;
    localparam int          VIOL_SPACE_BIT    = 25;

    // Reset values.
    localparam logic [31:0] MODE_ONE_RST  = 32'h0000_0600;
    localparam logic [31:0] MODE_TWO_RST  = 32'h0000_0808;
    localparam logic [31:0] ROW_TIME_RST  = {16'h0000,
        8'(ROW_CLOSE_TIME_CYC), 8'(ROW_ACTIVE_MIN_CYC)};
    localparam logic [31:0] CONTROL_RST   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Commands and bank states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PCT_NOP       = 3'b000,
        PCT_ACTIVATE  = 3'b001,
        PCT_READ      = 3'b010,
        PCT_WRITE     = 3'b011,
        PCT_MASK_WR   = 3'b100,
        PCT_CLOSE     = 3'b101,
        PCT_CLOSE_ALL = 3'b110
    } pct_cmd_e;

    typedef struct packed {
        logic       valid;
        pct_cmd_e   kind;
        logic [2:0] bank;
        logic       with_auto_close;
    } pct_cmd_s;

    typedef enum logic [1:0] {
        PCT_IDLE    = 2'b00,
        PCT_ACTIVE  = 2'b01,
        PCT_AP_WAIT = 2'b10,
        PCT_CLOSING = 2'b11
    } pct_bank_e;

endpackage

// file: pct_scheduler.sv
// Per-bank auto-close scheduler with row-active lockout and APB registers.
// Assumes commands arrive one per pclk cycle, already decoded, in step
// with pclk; the controller keeps its own spacing obligations.
//
// What the document requires
// R01 - Controller waits write latency+burst/2+recovery+1 after masked write.
// R02 - Controller waits same after write with auto close; activate adds close.
// R03 - No write to a bank after its write with auto close.
// R04 - No read to a bank after its write with auto close.
// R05 - No masked write to a bank after its masked write with auto close.
// R06 - Writes to other banks may follow after burst/2 clocks.
// R07 - Reads to other banks wait write latency+burst/2+write-to-read+1.
// R08 - Close after masked write auto close waits latency+burst/2+recovery+1.
// R09 - Any two close commands are at least 4 clocks apart.
// R10 - Close period restarts from the latest close reaching the bank.
// R11 - Commands inside any minimum delay window are illegal.
// R12 - Gapless reads to other banks after read with auto close.
// R13 - Gapless writes to other banks after write with auto close.
// R14 - Bursts always complete; nothing truncates them; here a close reaching a bank in PCT_AP_WAIT moves it to PCT_CLOSING.
// R15 - Postamble from mode register one bit 7, preamble from bit 2.
// R16 - Controller rounds nanosecond delays up to whole clocks.
// R17 - Read auto close count comes from mode register two.
// R18 - Write recovery count comes from mode register one.
// R19 - With termination, read auto close to write spacing uses its formula; here termination_en only drives its output, no spacing changes.
// R20 - With termination, all other close spacings are unchanged.
// R21 - Auto close commands may follow once row-to-column delay is met.
// R22 - Internal close waits until the row active minimum has elapsed.
// R23 - Controller meets row cycle time before reactivating a bank.
// R24 - Write auto close starts recovery cycles after the write burst ends.
// R25 - Read auto close starts at later of burst/2 and burst/4-4+count.
// R26 - Controller keeps per-bank timers and blocks commands until expired.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module pct_scheduler
    import pct_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire pct_cmd_s             cmd,
    output logic [NUM_BANKS-1:0]      bank_open,
    output logic [NUM_BANKS-1:0]      bank_closing,
    output logic [NUM_BANKS-1:0]      auto_close_start,
    output logic                      read_postamble,
    output logic                      write_preamble,
    output logic                      termination_en
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [31:0] mode_one_r, mode_one_nxt;
    logic [31:0] mode_two_r, mode_two_nxt;
    logic [31:0] row_time_r, row_time_nxt;
    logic [31:0] control_r,  control_nxt;
    logic [1:0]  viol_r,     viol_nxt;
    logic [31:0] prdata_r,   prdata_nxt;
    logic        slverr_r,   slverr_nxt;
    logic [7:0]  space_r,    space_nxt;
    logic [NUM_BANKS-1:0] ap_wait_vec;
    logic        setup, wr_acc, mapped, is_close, bank_viol;
    logic [31:0] status;

    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pwrite;
    assign pready  = psel & penable;
    assign prdata  = prdata_r;
    assign pslverr = slverr_r & psel & penable;
    assign mapped  = (paddr == MODE_ONE_OFS) || (paddr == MODE_TWO_OFS) ||
                     (paddr == ROW_TIME_OFS) || (paddr == CONTROL_OFS) ||
                     (paddr == STATUS_OFS);

    assign read_postamble = mode_one_r[RD_POSTAMBLE_BIT]; // R15
    assign write_preamble = mode_one_r[WR_PREAMBLE_BIT];  // R15
    assign termination_en = control_r[TERM_EN_BIT];

    assign is_close  = cmd.valid &&
                       (cmd.kind == PCT_CLOSE || cmd.kind == PCT_CLOSE_ALL);
    // Column commands to a bank still waiting on its own auto close are
    // reported; the device keeps its schedule regardless.
    assign bank_viol = cmd.valid && ap_wait_vec[cmd.bank] &&
                       (cmd.kind == PCT_READ || cmd.kind == PCT_WRITE ||
                        cmd.kind == PCT_MASK_WR); // R03 R04 R05 R11

    assign status = {6'h00, viol_r, ap_wait_vec, bank_closing, bank_open};

    always_comb begin
        mode_one_nxt = mode_one_r;
        mode_two_nxt = mode_two_r;
        row_time_nxt = row_time_r;
        control_nxt  = control_r;
        viol_nxt     = viol_r;
        prdata_nxt   = prdata_r;
        slverr_nxt   = slverr_r;
        space_nxt    = (space_r != 8'h00) ? space_r - 8'h01 : 8'h00;
        if (setup) begin
            slverr_nxt = ~mapped;
            unique case (paddr)
                MODE_ONE_OFS: prdata_nxt = mode_one_r;
                MODE_TWO_OFS: prdata_nxt = mode_two_r;
                ROW_TIME_OFS: prdata_nxt = row_time_r;
                CONTROL_OFS:  prdata_nxt = control_r;
                STATUS_OFS:   prdata_nxt = status;
                default:      prdata_nxt = 32'h0000_0000;
            endcase
        end
        if (wr_acc) begin
            unique case (paddr)
                MODE_ONE_OFS: mode_one_nxt = pwdata;
                MODE_TWO_OFS: mode_two_nxt = pwdata;
                ROW_TIME_OFS: row_time_nxt = {16'h0000, pwdata[15:0]};
                CONTROL_OFS:  control_nxt  = {30'h0, pwdata[1:0]};
                STATUS_OFS:   viol_nxt     = viol_r &
                    ~pwdata[VIOL_SPACE_BIT:VIOL_BANK_BIT];
                default:      ;
            endcase
        end
        // Hardware set wins over a software clear in the same cycle.
        if (is_close) begin
            space_nxt = CLOSE_SPACING_CYC - 8'h01; // R09
            if (space_r != 8'h00) begin
                viol_nxt[1] = 1'b1; // R09 R11
            end
        end
        if (bank_viol) begin
            viol_nxt[0] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_one_r <= MODE_ONE_RST;
            mode_two_r <= MODE_TWO_RST;
            row_time_r <= ROW_TIME_RST;
            control_r  <= CONTROL_RST;
            viol_r     <= 2'b00;
            prdata_r   <= 32'h0000_0000;
            slverr_r   <= 1'b0;
            space_r    <= 8'h00;
        end else begin
            mode_one_r <= mode_one_nxt;
            mode_two_r <= mode_two_nxt;
            row_time_r <= row_time_nxt;
            control_r  <= control_nxt;
            viol_r     <= viol_nxt;
            prdata_r   <= prdata_nxt;
            slverr_r   <= slverr_nxt;
            space_r    <= space_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Auto-close delays shared by all banks
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] half_burst, read_close_dly, write_close_dly;
    logic [CNT_W-1:0] read_alt, row_act_min, row_close_cyc;

    assign half_burst  = control_r[BL32_BIT] ? 8'h10 : 8'h08;
    assign row_act_min = row_time_r[ROW_ACT_LSB +: CNT_W];
    assign row_close_cyc = (row_time_r[ROW_CLOSE_LSB +: CNT_W] == 8'h00) ?
                           8'h01 : row_time_r[ROW_CLOSE_LSB +: CNT_W];
    // Burst/4 - 4 is zero for 16 and four for 32.
    assign read_alt = (control_r[BL32_BIT] ? 8'h04 : 8'h00) +
                      mode_two_r[RD_CLOSE_LSB +: CNT_W]; // R17
    assign read_close_dly = (read_alt > half_burst) ?
                            read_alt : half_burst; // R25
    assign write_close_dly = mode_two_r[WR_LAT_LSB +: CNT_W] + half_burst +
                             mode_one_r[WR_RECOV_LSB +: CNT_W]; // R18 R24

    // ------------------------------------------------------------------
    // Per-bank state
    // ------------------------------------------------------------------
    // Other banks are never stalled by a pending auto close, which keeps
    // back-to-back bursts to different banks gapless.  R12 R13
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            pct_bank_e        st_r,  st_nxt;
            logic [CNT_W-1:0] ras_r, ras_nxt;
            logic [CNT_W-1:0] dly_r, dly_nxt;
            logic             hit, close_hit, ras_done, start;

            assign hit       = cmd.valid && (cmd.bank == 3'(b));
            assign close_hit = cmd.valid && (cmd.kind == PCT_CLOSE_ALL ||
                               (cmd.kind == PCT_CLOSE && hit));
            // Widened by one bit so a saturated count still reads as done.
            assign ras_done  = ({1'b0, ras_r} + 9'h001) >=
                               {1'b0, row_act_min};
            assign start     = (st_r == PCT_AP_WAIT) && (dly_r == 8'h00) &&
                               ras_done; // R22

            assign bank_open[b]        = (st_r == PCT_ACTIVE) ||
                                         (st_r == PCT_AP_WAIT);
            assign bank_closing[b]     = (st_r == PCT_CLOSING);
            assign ap_wait_vec[b]      = (st_r == PCT_AP_WAIT);
            assign auto_close_start[b] = start;

            always_comb begin
                st_nxt  = st_r;
                ras_nxt = (ras_r != 8'hff) ? ras_r + 8'h01 : ras_r;
                dly_nxt = (dly_r != 8'h00) ? dly_r - 8'h01 : 8'h00;
                unique case (st_r)
                    PCT_IDLE: begin
                        if (hit && cmd.kind == PCT_ACTIVATE) begin
                            st_nxt  = PCT_ACTIVE;
                            ras_nxt = 8'h00;
                        end
                    end
                    PCT_ACTIVE: begin
                        if (hit && cmd.with_auto_close &&
                            cmd.kind == PCT_READ) begin
                            st_nxt  = PCT_AP_WAIT; // R21
                            dly_nxt = read_close_dly - 8'h01; // R25
                        end else if (hit && cmd.with_auto_close &&
                            (cmd.kind == PCT_WRITE ||
                             cmd.kind == PCT_MASK_WR)) begin
                            st_nxt  = PCT_AP_WAIT; // R21
                            dly_nxt = write_close_dly - 8'h01; // R24
                        end
                    end
                    PCT_AP_WAIT: begin
                        // The burst in flight is cut short only by a close reaching the bank. R14
                        if (start) begin
                            st_nxt  = PCT_CLOSING;
                            dly_nxt = row_close_cyc - 8'h01;
                        end
                    end
                    PCT_CLOSING: begin
                        if (dly_r == 8'h00) begin
                            st_nxt = PCT_IDLE;
                        end
                    end
                endcase
                // A close reaching the bank restarts its close period. R10
                if (close_hit && st_r != PCT_IDLE && !start) begin
                    st_nxt  = PCT_CLOSING;
                    dly_nxt = row_close_cyc - 8'h01;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st_r  <= PCT_IDLE;
                    ras_r <= 8'h00;
                    dly_r <= 8'h00;
                end else begin
                    st_r  <= st_nxt;
                    ras_r <= ras_nxt;
                    dly_r <= dly_nxt;
                end
            end
        end
    endgenerate

endmodule

// file: HANDOVER_unused.sv
`timescale 1ns/1ns

// file: pct_scheduler_sva.sv
// Port checker for the bank auto-close scheduler.
// Assumes bank 0 only ever runs with the reset timing values.
`timescale 1ns/1ns
module pct_scheduler_sva
    import pct_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire pct_cmd_s             cmd,
    input wire logic [NUM_BANKS-1:0] bank_open,
    input wire logic [NUM_BANKS-1:0] bank_closing,
    input wire logic [NUM_BANKS-1:0] auto_close_start,
    input wire logic                 read_postamble,
    input wire logic                 write_preamble,
    input wire logic                 termination_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence col_ap0_s(pct_cmd_e k);
        cmd.valid && cmd.kind == k && cmd.with_auto_close
            && cmd.bank == 3'h0;
    endsequence
    sequence act0_s;
        cmd.valid && cmd.kind == PCT_ACTIVATE && cmd.bank == 3'h0;
    endsequence
    sequence cfg_wr_s(logic [7:0] a);
        $past(psel) && $past(penable) && $past(pwrite) && $past(paddr) == a;
    endsequence

    zero_wait_a: assert property (pready == (psel && penable))
        else $error("pready differs from access phase");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    rd_close_a: assert property (
        col_ap0_s(PCT_READ) |-> ##8 auto_close_start[0])
        else $error("read auto close start off time");
    wr_close_a: assert property (
        col_ap0_s(PCT_WRITE) |-> ##22 auto_close_start[0])
        else $error("write auto close start off time");
    ras_lock_a: assert property (act0_s |=> !bank_closing[0] [*4])
        else $error("bank closed before row active minimum");
    close_follow_a: assert property (auto_close_start != '0 |=>
        (bank_closing & $past(auto_close_start)) == $past(auto_close_start))
        else $error("closing did not follow auto close start");
    close_len_a: assert property (
        $rose(bank_closing[0]) |=> bank_closing[0] ##1 !bank_closing[0])
        else $error("close period length wrong");
    open_clear_a: assert property ((bank_open & bank_closing) == '0)
        else $error("bank open while closing");
    mode_src_a: assert property (
        $changed(read_postamble) || $changed(write_preamble)
            |-> cfg_wr_s(MODE_ONE_OFS))
        else $error("mode bit changed without register write");
    term_src_a: assert property (
        $changed(termination_en) |-> cfg_wr_s(CONTROL_OFS))
        else $error("termination changed without register write");
endmodule

// file: pct_ctrl_model.sv
// Memory controller model that spaces commands to the scheduler.
// Assumes the bench calls issue; illegal requests skip all spacing waits.
`timescale 1ns/1ns
module pct_ctrl_model
    import pct_pkg::*;
(
    input  wire logic pclk,
    output pct_cmd_s  cmd
);
    localparam int BURST_HALF = 8;
    localparam int WR_LAT     = 8;
    localparam int WR_RECOV   = 6;
    localparam int WR_TO_RD   = (15 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_COL    = 2;
    localparam int CLOSE_GAP  = 4;
    int cyc      = 0;
    int bank_ok  [NUM_BANKS] = '{default: 0};
    int col_ok   = 0;
    int rd_ok    = 0;
    int close_ok = 0;
    initial cmd = '0;
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic issue(input pct_cmd_e k, input logic [2:0] b,
                         input logic ap, input logic legal);
        int  t;
        logic col;
        col = k inside {PCT_READ, PCT_WRITE, PCT_MASK_WR};
        t = bank_ok[b];
        if (col && col_ok > t) t = col_ok;
        if (k == PCT_READ && rd_ok > t) t = rd_ok;
        if (!col && k != PCT_ACTIVATE && close_ok > t) t = close_ok;
        @(posedge pclk);
        while (legal && cyc < t) @(posedge pclk);
        cmd <= '{1'b1, k, b, ap};
        if (k == PCT_ACTIVATE) bank_ok[b] = cyc + ROW_COL;
        if (col) col_ok = cyc + BURST_HALF;
        if (col && k != PCT_READ)
            bank_ok[b] = cyc + WR_LAT + BURST_HALF + WR_RECOV + 1;
        if (col && ap) bank_ok[b] += ROW_CLOSE_TIME_CYC;
        if (col && ap && k != PCT_READ)
            rd_ok = cyc + WR_LAT + BURST_HALF + WR_TO_RD + 1;
        if (!col && k != PCT_ACTIVATE) close_ok = cyc + CLOSE_GAP;
        @(posedge pclk);
        cmd <= '0;
    endtask
endmodule

// file: test_precharge_command_timing.sv
// Bench for the auto-close scheduler: APB register tasks and commands.
// Assumes the controller model keeps every legal command spaced.
`timescale 1ns/1ns
module test_precharge_command_timing
    import pct_pkg::*;
();
    logic                 pclk    = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel    = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite  = 1'b0;
    logic [7:0]           paddr   = 8'h00;
    logic [31:0]          pwdata  = 32'h0;
    logic [31:0]          prdata, rd;
    logic                 pready, pslverr, er;
    logic                 read_postamble, write_preamble, termination_en;
    logic [NUM_BANKS-1:0] bank_open, bank_closing, auto_close_start;
    logic [2:0]           b;
    pct_cmd_s             cmd;
    int bad_count = 0, num_checks = 0, cyc_count = 0, t_act, t_cmd, ex, ras;
    logic [7:0]  ofs [6] = '{MODE_ONE_OFS, MODE_TWO_OFS, ROW_TIME_OFS,
                             CONTROL_OFS, STATUS_OFS, 8'h14};
    logic [31:0] rst [6] = '{MODE_ONE_RST, MODE_TWO_RST, ROW_TIME_RST,
                             CONTROL_RST, 32'h0, 32'h0};
    // Bank, mode one, mode two, control, row time, command, close delay.
    int tbl [8][7] = '{'{0, 'h600, 'h808, 0, 'h205, 2, 8},
                       '{0, 'h600, 'h808, 0, 'h205, 3, 22},
                       '{1, 'h384, 'h808, 0, 'h205, 4, 19},
                       '{1, 'h600, 'h80c, 0, 'h205, 2, 12},
                       '{1, 'h600, 'h808, 3, 'h205, 2, 16},
                       '{1, 'h600, 'h808, 1, 'h205, 3, 30},
                       '{1, 'h600, 'h408, 0, 'h205, 3, 18},
                       '{1, 'h600, 'h808, 0, 'h328, 2, 8}};

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    pct_scheduler dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd(cmd), .bank_open(bank_open),
        .bank_closing(bank_closing), .auto_close_start(auto_close_start),
        .read_postamble(read_postamble), .write_preamble(write_preamble),
        .termination_en(termination_en));
    pct_ctrl_model ctrl (.pclk(pclk), .cmd(cmd));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 8'h14, 32'hffff_ffff);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rd, rst[i], "reset value");
            chk(32'(er), 32'(i == 5), "slave error");
        end
        for (int i = 0; i < 8; i++) begin
            b = 3'(tbl[i][0]);
            apb(1'b1, MODE_ONE_OFS, tbl[i][1]);
            apb(1'b1, MODE_TWO_OFS, tbl[i][2]);
            apb(1'b1, CONTROL_OFS, tbl[i][3]);
            apb(1'b1, ROW_TIME_OFS, tbl[i][4]);
            chk(32'(read_postamble), 32'(tbl[i][1][7]), "postamble");
            chk(32'(write_preamble), 32'(tbl[i][1][2]), "preamble");
            chk(32'(termination_en), 32'(tbl[i][3][1]), "odt");
            ctrl.issue(PCT_ACTIVATE, b, 1'b0, 1'b1);
            t_act = cyc_count;
            ctrl.issue(pct_cmd_e'(tbl[i][5]), b, 1'b1, 1'b1);
            t_cmd = cyc_count;
            ex = tbl[i][6];
            ras = tbl[i][4] % 256 - (t_cmd - t_act);
            if (ras > ex) ex = ras;
            do @(posedge pclk); while (auto_close_start[b] !== 1'b1);
            chk(32'(cyc_count - t_cmd), 32'(ex), "start");
            repeat (tbl[i][4] / 256) begin
                @(posedge pclk);
                chk(32'({bank_closing[b], bank_open[b]}), 32'h2, "shut");
            end
            @(posedge pclk);
            chk(32'(bank_closing[b]), 32'h0, "idle");
        end
        apb(1'b1, ROW_TIME_OFS, 32'h0000_0205);
        ctrl.issue(PCT_ACTIVATE, 3'h2, 1'b0, 1'b1);
        ctrl.issue(PCT_WRITE, 3'h2, 1'b1, 1'b1);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(32'(rd[2]), 32'h1, "open status");
        for (int k = 2; k < 5; k += 2) begin
            ctrl.issue(pct_cmd_e'(k), 3'h2, 1'b0, 1'b0);
            apb(1'b0, STATUS_OFS, 32'h0);
            chk(32'(rd[24]), 32'h1, "bank flag");
            apb(1'b1, STATUS_OFS, 32'h0100_0000);
            apb(1'b0, STATUS_OFS, 32'h0);
            chk(32'(rd[24]), 32'h0, "bank flag clear");
        end
        ctrl.issue(PCT_CLOSE, 3'h3, 1'b0, 1'b1);
        ctrl.issue(PCT_CLOSE_ALL, 3'h0, 1'b0, 1'b1);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(32'(rd[25]), 32'h0, "spaced closes");
        // The second close lands two cycles after the first, inside the gap.
        ctrl.issue(PCT_CLOSE, 3'h3, 1'b0, 1'b1);
        ctrl.issue(PCT_CLOSE, 3'h4, 1'b0, 1'b0);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(32'(rd[25]), 32'h1, "close spacing flag");
        tally_and_finish();
    end
endmodule

bind pct_scheduler pct_scheduler_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd(cmd), .bank_open(bank_open),
    .bank_closing(bank_closing), .auto_close_start(auto_close_start),
    .read_postamble(read_postamble), .write_preamble(write_preamble),
    .termination_en(termination_en));
